// >>> overcurrent_pickup.sv
// Pickup threshold and measured quantity for one phase overcurrent element.
// Assumes magnitudes and phasors arrive synchronous with sample_valid; one 40 MHz clock.
`timescale 1ns/10ps
`include "overcurrent_cfg.svh"
module overcurrent_pickup
  import overcurrent_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rstn,
  // Register port
  input  wire logic [7:0]  addr,
  input  wire logic [31:0] wr_data,
  input  wire logic        wr_en,
  input  wire logic        rd_en,
  output logic      [31:0] rd_data,
  // Measurements
  input  wire logic        sample_valid,
  input  wire logic [15:0] v_pp_mag,
  input  wire logic [15:0] v_pg_mag,
  input  wire logic [15:0] i1_re,
  input  wire logic [15:0] i1_im,
  input  wire logic [15:0] i2_re,
  input  wire logic [15:0] i2_im,
  input  wire logic [15:0] i3_re,
  input  wire logic [15:0] i3_im,
  // Supervision and adaptive trigger
  input  wire logic        vts_mcb_trip,
  input  wire logic        undervoltage_pickup,
  // Element outputs
  output logic             element_pickup,
  output logic             restraint_blocked,
  output logic [3:0]       active_curve,
  output logic [1:0]       active_reset_mode,
  output logic [7:0]       active_tmult,
  output logic [15:0]      measured_quantity,
  output logic [15:0]      effective_pickup,
  output logic             irq
);

  // ==================================================================
  // Helpers
  function automatic logic [15:0] abs16(input logic signed [15:0] x);
    abs16 = x[15] ? 16'(-x) : 16'(x);
  endfunction : abs16

  // Alpha-max plus beta-min magnitude, saturating
  function automatic logic [15:0] mag(input logic [15:0] re, input logic [15:0] im);
    logic [15:0] a;
    logic [15:0] b;
    logic [15:0] hi;
    logic [15:0] lo;
    logic [16:0] s;
    a  = abs16(re);
    b  = abs16(im);
    hi = (a > b) ? a : b;
    lo = (a > b) ? b : a;
    s  = {1'b0, hi} + {3'b000, lo[15:2]} + {4'b0000, lo[15:3]};
    mag = s[16] ? 16'hffff : s[15:0];
  endfunction : mag

  function automatic logic [15:0] max3(input logic [15:0] a, input logic [15:0] b,
                                       input logic [15:0] c);
    logic [15:0] m;
    m    = (a > b) ? a : b;
    max3 = (m > c) ? m : c;
  endfunction : max3

  // ==================================================================
  // Settings registers
  logic [`CTRL_W-1:0] ctrl_reg,     ctrl_next;
  param_set_t         set_nrm_reg,  set_nrm_next;
  param_set_t         set_alt_reg,  set_alt_next;
  logic [15:0]        pickup_reg,   pickup_next;
  logic [15:0]        minpick_reg,  minpick_next;
  logic [15:0]        rating_reg,   rating_next;
  logic [15:0]        ufact_reg,    ufact_next;
  logic [`INT_W-1:0]  istat_reg,    istat_next;
  logic [`INT_W-1:0]  imask_reg,    imask_next;
  logic [31:0]        rd_data_reg,  rd_data_next;

  // ==================================================================
  // Element state
  logic        start_reg,   start_next;
  logic        pick_reg,    pick_next;
  logic        block_reg,   block_next;
  logic        alt_reg,     alt_next;
  logic [15:0] meas_reg,    meas_next;
  logic [15:0] volt_reg,    volt_next;
  logic [15:0] vmax_reg,    vmax_next;
  logic        act_reg,     act_next;
  logic [3:0]  curve_reg,   curve_next;
  logic [1:0]  rmode_reg,   rmode_next;
  logic [7:0]  tmult_reg,   tmult_next;
  logic        irq_reg,     irq_next;

  restraint_if rif ();

  restraint_calc u_calc (
    .clk  (clk),
    .rstn (rstn),
    .rif  (rif.calc)
  );

  logic                alt_sel;
  param_set_t          set_act;
  logic                blocked;
  logic                meas_pp;
  logic                vn_reduced;
  logic [32:0]         vn_prod;
  logic [15:0]         vn;
  logic [31:0]         vmax_prod;
  logic signed [47:0]  ns_re;
  logic signed [47:0]  ns_im;
  logic signed [47:0]  ns_re3;
  logic signed [47:0]  ns_im3;
  logic [15:0]         ineg;
  logic [15:0]         iphase;
  logic [`INT_W-1:0]   events;
  logic                wr_hit_istat;

  // ==================================================================
  // Measurement and threshold path
  always_comb begin
    alt_sel    = ctrl_reg[`CTRL_ADAPT_EN] & undervoltage_pickup;           // [RULE14]
    set_act    = alt_sel ? set_alt_reg : set_nrm_reg;                      // [RULE14]
    blocked    = ctrl_reg[`CTRL_VTS_EN] & vts_mcb_trip;                    // [RULE7]
    meas_pp    = ctrl_reg[`CTRL_VT_CONN_PP] | ctrl_reg[`CTRL_MEAS_PP];     // [RULE9]
    vn_reduced = !ctrl_reg[`CTRL_VT_CONN_PP] && !ctrl_reg[`CTRL_MEAS_PP];  // [RULE8]
    vn_prod    = rating_reg * `INV_SQRT3_Q16;
    vn         = vn_reduced ? vn_prod[31:16] : rating_reg;                 // [RULE8] [RULE9]
    vmax_prod  = vn * ufact_reg;
    // Symmetrical component, Q15 rotation terms then divide by three
    ns_re  = (48'(signed'(i1_re)) <<< 15)
           - ((48'(signed'(i2_re)) + 48'(signed'(i3_re))) <<< 14)
           + (48'(signed'(i2_im)) - 48'(signed'(i3_im))) * 48'(`HALF_SQRT3_Q15);  // [RULE11]
    ns_im  = (48'(signed'(i1_im)) <<< 15)
           - ((48'(signed'(i2_im)) + 48'(signed'(i3_im))) <<< 14)
           + (48'(signed'(i3_re)) - 48'(signed'(i2_re))) * 48'(`HALF_SQRT3_Q15);  // [RULE11]
    ns_re3 = ns_re * 48'(`THIRD_Q15);
    ns_im3 = ns_im * 48'(`THIRD_Q15);
    ineg   = mag(ns_re3[45:30], ns_im3[45:30]);                            // [RULE11]
    iphase = max3(mag(i1_re, i1_im), mag(i2_re, i2_im), mag(i3_re, i3_im));

    start_next = sample_valid & ~rif.busy & ~start_reg;
    volt_next  = volt_reg;
    vmax_next  = vmax_reg;
    act_next   = act_reg;
    meas_next  = meas_reg;
    if (sample_valid) begin
      volt_next = meas_pp ? v_pp_mag : v_pg_mag;                           // [RULE2]
      vmax_next = (vmax_prod[31:24] != 8'h00) ? 16'hffff : vmax_prod[23:8];
      act_next  = set_act.restraint_en & ~blocked;                         // [RULE1] [RULE15]
      meas_next = ctrl_reg[`CTRL_NEG_SEQ] ? ineg : iphase;                 // [RULE10]
    end
    // Same set drives both phase and negative-sequence operation
    curve_next = set_act.curve;                                            // [RULE6] [RULE12]
    rmode_next = set_act.reset_mode;                                       // [RULE6] [RULE12]
    tmult_next = set_act.tmult;                                            // [RULE6] [RULE12]
    alt_next   = alt_sel;
    block_next = blocked & set_act.restraint_en;                           // [RULE7]
    // Blocked restrained element cannot pick up even on stale threshold
    pick_next  = (meas_reg > rif.eff) & ~block_next;                       // [RULE7]
  end

  assign rif.start      = start_reg;
  assign rif.active     = act_reg;
  assign rif.volt       = volt_reg;
  assign rif.vmax       = vmax_reg;
  assign rif.pickup     = pickup_reg;
  assign rif.min_pickup = minpick_reg;

  // ==================================================================
  // Register port and interrupts
  always_comb begin
    ctrl_next    = ctrl_reg;
    set_nrm_next = set_nrm_reg;
    set_alt_next = set_alt_reg;
    pickup_next  = pickup_reg;
    minpick_next = minpick_reg;
    rating_next  = rating_reg;
    ufact_next   = ufact_reg;
    imask_next   = imask_reg;
    wr_hit_istat = wr_en && (addr == `REG_INT_STATUS);
    if (wr_en) begin
      case (addr)
        `REG_CTRL:       ctrl_next    = wr_data[`CTRL_W-1:0];
        `REG_SET_NORMAL: set_nrm_next = param_set_t'(wr_data[15:0]);
        `REG_SET_ALT:    set_alt_next = param_set_t'(wr_data[15:0]);
        `REG_PICKUP:     pickup_next  = wr_data[15:0];
        `REG_MIN_PICKUP: minpick_next = wr_data[15:0];
        `REG_VT_RATING:  rating_next  = wr_data[15:0];
        `REG_UPPER_FACT: ufact_next   = wr_data[15:0];
        `REG_INT_MASK:   imask_next   = wr_data[`INT_W-1:0];
        default: begin
        end
      endcase
    end
    events = '0;
    events[`INT_PICKUP]     = pick_next & ~pick_reg;
    events[`INT_BLOCK]      = block_next & ~block_reg;
    events[`INT_SET_CHANGE] = alt_next ^ alt_reg;
    // A new event in the clearing cycle survives the write-one-to-clear
    istat_next = (istat_reg & ~(wr_hit_istat ? wr_data[`INT_W-1:0] : '0)) | events;
    irq_next   = |(istat_next & imask_next);
    rd_data_next = 32'h0000_0000;
    if (rd_en) begin
      case (addr)
        `REG_CTRL:       rd_data_next = {27'h0, ctrl_reg};
        `REG_SET_NORMAL: rd_data_next = {16'h0, set_nrm_reg};
        `REG_SET_ALT:    rd_data_next = {16'h0, set_alt_reg};
        `REG_PICKUP:     rd_data_next = {16'h0, pickup_reg};
        `REG_MIN_PICKUP: rd_data_next = {16'h0, minpick_reg};
        `REG_VT_RATING:  rd_data_next = {16'h0, rating_reg};
        `REG_UPPER_FACT: rd_data_next = {16'h0, ufact_reg};
        `REG_STATE:      rd_data_next = {28'h0, pick_reg, alt_reg, block_reg, act_reg};
        `REG_PERCENT:    rd_data_next = {23'h0, rif.pct};
        `REG_EFF_PICKUP: rd_data_next = {16'h0, rif.eff};
        `REG_MEASURED:   rd_data_next = {16'h0, meas_reg};
        `REG_INT_STATUS: rd_data_next = {29'h0, istat_reg};
        `REG_INT_MASK:   rd_data_next = {29'h0, imask_reg};
        default:         rd_data_next = 32'h0000_0000;
      endcase
    end
  end

  // ==================================================================
  // Flip-flops
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ctrl_reg    <= `CTRL_RST;
      set_nrm_reg <= param_set_t'(`SET_RST);
      set_alt_reg <= param_set_t'(`SET_RST);
      pickup_reg  <= `PICKUP_RST;
      minpick_reg <= `MIN_PICKUP_RST;
      rating_reg  <= `VT_RATING_RST;
      ufact_reg   <= `UPPER_FACT_RST;
      istat_reg   <= '0;
      imask_reg   <= '0;
      rd_data_reg <= 32'h0000_0000;
      start_reg   <= 1'b0;
      pick_reg    <= 1'b0;
      block_reg   <= 1'b0;
      alt_reg     <= 1'b0;
      meas_reg    <= 16'h0000;
      volt_reg    <= 16'h0000;
      vmax_reg    <= 16'h0000;
      act_reg     <= 1'b0;
      curve_reg   <= 4'h0;
      rmode_reg   <= 2'h0;
      tmult_reg   <= 8'h00;
      irq_reg     <= 1'b0;
    end else begin
      ctrl_reg    <= ctrl_next;
      set_nrm_reg <= set_nrm_next;
      set_alt_reg <= set_alt_next;
      pickup_reg  <= pickup_next;
      minpick_reg <= minpick_next;
      rating_reg  <= rating_next;
      ufact_reg   <= ufact_next;
      istat_reg   <= istat_next;
      imask_reg   <= imask_next;
      rd_data_reg <= rd_data_next;
      start_reg   <= start_next;
      pick_reg    <= pick_next;
      block_reg   <= block_next;
      alt_reg     <= alt_next;
      meas_reg    <= meas_next;
      volt_reg    <= volt_next;
      vmax_reg    <= vmax_next;
      act_reg     <= act_next;
      curve_reg   <= curve_next;
      rmode_reg   <= rmode_next;
      tmult_reg   <= tmult_next;
      irq_reg     <= irq_next;
    end
  end

  assign rd_data           = rd_data_reg;
  assign element_pickup    = pick_reg;
  assign restraint_blocked = block_reg;
  assign active_curve      = curve_reg;
  assign active_reset_mode = rmode_reg;
  assign active_tmult      = tmult_reg;
  assign measured_quantity = meas_reg;
  // Comes straight from the calculator's output flip-flop
  assign effective_pickup  = rif.eff;
  assign irq               = irq_reg;

endmodule : overcurrent_pickup

// >>> overcurrent_cfg.svh
// Constants for the overcurrent pickup and restraint block: register map,
// field positions, reset values and fixed-point factors.
// Assumes the includer works in Q8 percent (0x100 = 100 percent) and 16-bit magnitudes.
// Function
// (RULE1) Restraint only when the active set's restraint enable is on.
// (RULE2) Restraint voltage is phase-to-phase or phase-to-ground per measuring mode.
// (RULE3) Percent: 25 below lower, 100 above upper, slope 1/upper between; lower=upper/4.
// (RULE4) Effective pickup is pickup setting times restraint percent.
// (RULE5) Effective pickup below the minimum setting is replaced by the minimum.
// (RULE6) Curve, reset mode and time multiplier pass unchanged by restraint.
// (RULE7) Enabled transformer supervision reporting breaker trip blocks the restrained element.
// (RULE8) Ground connection with ground measuring gives nominal equal rating over root three.
// (RULE9) Otherwise nominal equals rating; phase connection forces phase-to-phase measuring.
// (RULE10) Negative sequence selection compares negative-sequence current, not phase currents.
// (RULE11) Negative sequence is one third of L1 plus a-squared L2 plus a L3.
// (RULE12) Negative sequence mode uses the same curve, reset and multiplier settings.
// (RULE13) Software keeps current trip delays at least 30 ms when inrush blocking is used.
// (RULE14) Assigned undervoltage pickup selects the alternative set while asserted.
// (RULE15) Without restraint, or when blocked, pickup setting is used unchanged.
`ifndef OVERCURRENT_CFG_SVH
`define OVERCURRENT_CFG_SVH

// ==================================================================
// Register map (byte addresses)
`define REG_CTRL        8'h00
`define REG_SET_NORMAL  8'h04
`define REG_SET_ALT     8'h08
`define REG_PICKUP      8'h0c
`define REG_MIN_PICKUP  8'h10
`define REG_VT_RATING   8'h14
`define REG_UPPER_FACT  8'h18
`define REG_STATE       8'h1c
`define REG_PERCENT     8'h20
`define REG_EFF_PICKUP  8'h24
`define REG_MEASURED    8'h28
`define REG_INT_STATUS  8'h2c
`define REG_INT_MASK    8'h30

// ==================================================================
// Control fields
`define CTRL_VT_CONN_PP  0
`define CTRL_MEAS_PP     1
`define CTRL_NEG_SEQ     2
`define CTRL_VTS_EN      3
`define CTRL_ADAPT_EN    4
`define CTRL_W           5

// ==================================================================
// Interrupt fields
`define INT_PICKUP       0
`define INT_BLOCK        1
`define INT_SET_CHANGE   2
`define INT_W            3

// ==================================================================
// Reset values
`define CTRL_RST         5'h00
`define SET_RST          16'h0000
`define PICKUP_RST       16'h1000
`define MIN_PICKUP_RST   16'h0100
`define VT_RATING_RST    16'h0064
`define UPPER_FACT_RST   16'h0100

// ==================================================================
// Fixed-point factors
`define PCT_FULL         9'h100
`define PCT_MIN          9'h040
`define PCT_SHIFT        8
`define LOWER_SHIFT      2
`define INV_SQRT3_Q16    17'h093cd
`define HALF_SQRT3_Q15   16'h6eda
`define THIRD_Q15        16'h2aab
`define DIV_LAST         3'h7

`endif

// >>> overcurrent_pkg.sv
// Types shared by the overcurrent pickup block and its restraint calculator.
// Assumes the constants header is included by the user files.
package overcurrent_pkg;

  // ==================================================================
  // Calculator states, Gray along idle-divide-scale-done
  typedef enum logic [1:0] {
    CALC_IDLE  = 2'b00,
    CALC_DIV   = 2'b01,
    CALC_SCALE = 2'b11,
    CALC_DONE  = 2'b10
  } calc_state_t;

  // ==================================================================
  // One parameter set as software writes it
  typedef struct packed {
    logic [7:0] tmult;
    logic       spare;
    logic [1:0] reset_mode;
    logic [3:0] curve;
    logic       restraint_en;
  } param_set_t;

endpackage : overcurrent_pkg

// >>> restraint_if.sv
// Carrier between the pickup block and its restraint calculator.
// Assumes one clock; start is a one-cycle pulse, done likewise.
`timescale 1ns/10ps
interface restraint_if;
  logic        start;
  logic        active;
  logic [15:0] volt;
  logic [15:0] vmax;
  logic [15:0] pickup;
  logic [15:0] min_pickup;
  logic        busy;
  logic        done;
  logic [8:0]  pct;
  logic [15:0] eff;

  modport calc (input start, active, volt, vmax, pickup, min_pickup,
                output busy, done, pct, eff);
  modport ctl  (output start, active, volt, vmax, pickup, min_pickup,
                input busy, done, pct, eff);
endinterface : restraint_if

// >>> restraint_calc.sv
// Restraint percentage and effective pickup calculator.
// Assumes inputs are stable only in the start cycle; they are latched there.
`timescale 1ns/10ps
`include "overcurrent_cfg.svh"
module restraint_calc
  import overcurrent_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Calculator side of the carrier
  restraint_if.calc rif
);

  calc_state_t state_reg, state_next;
  logic [16:0] rem_reg,   rem_next;
  logic [7:0]  quo_reg,   quo_next;
  logic [2:0]  cnt_reg,   cnt_next;
  logic [15:0] vmax_reg,  vmax_next;
  logic [15:0] pick_reg,  pick_next;
  logic [15:0] min_reg,   min_next;
  logic        act_reg,   act_next;
  logic [8:0]  pct_reg,   pct_next;
  logic [15:0] eff_reg,   eff_next;
  logic        done_reg,  done_next;

  logic [15:0] vmin;
  logic [16:0] rem_sh;
  logic [24:0] prod;

  // ==================================================================
  // Next state
  always_comb begin
    state_next = state_reg;
    rem_next   = rem_reg;
    quo_next   = quo_reg;
    cnt_next   = cnt_reg;
    vmax_next  = vmax_reg;
    pick_next  = pick_reg;
    min_next   = min_reg;
    act_next   = act_reg;
    pct_next   = pct_reg;
    eff_next   = eff_reg;
    done_next  = 1'b0;
    vmin       = rif.vmax >> `LOWER_SHIFT;                           // [RULE3]
    rem_sh     = {rem_reg[15:0], 1'b0};
    prod       = pick_reg * pct_reg;
    case (state_reg)
      CALC_IDLE: begin
        if (rif.start) begin
          vmax_next = rif.vmax;
          pick_next = rif.pickup;
          min_next  = rif.min_pickup;
          act_next  = rif.active;
          quo_next  = 8'h00;
          cnt_next  = 3'h0;
          rem_next  = {1'b0, rif.volt - vmin};
          state_next = CALC_SCALE;
          if (!rif.active || rif.vmax == 16'h0000 || rif.volt >= rif.vmax) begin
            pct_next = `PCT_FULL;                                     // [RULE3] [RULE15]
          end else if (rif.volt <= vmin) begin
            pct_next = `PCT_MIN;                                      // [RULE3]
          end else begin
            state_next = CALC_DIV;
          end
        end
      end
      CALC_DIV: begin
        // Restoring division: eight quotient bits of (V - lower) * 256 / upper
        if (rem_sh >= {1'b0, vmax_reg}) begin
          rem_next = rem_sh - {1'b0, vmax_reg};
          quo_next = {quo_reg[6:0], 1'b1};
        end else begin
          rem_next = rem_sh;
          quo_next = {quo_reg[6:0], 1'b0};
        end
        cnt_next = cnt_reg + 3'h1;
        if (cnt_reg == `DIV_LAST) begin
          pct_next   = `PCT_MIN + {1'b0, quo_next};                   // [RULE3]
          state_next = CALC_SCALE;
        end
      end
      CALC_SCALE: begin
        eff_next = prod[23:8];                                        // [RULE4]
        if (!act_reg) begin
          eff_next = pick_reg;                                        // [RULE15]
        end else if (prod[23:8] < min_reg) begin
          eff_next = min_reg;                                         // [RULE5]
        end
        state_next = CALC_DONE;
      end
      CALC_DONE: begin
        done_next  = 1'b1;
        state_next = CALC_IDLE;
      end
      default: begin
        state_next = CALC_IDLE;
      end
    endcase
  end

  // ==================================================================
  // Registers
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_reg <= CALC_IDLE;
      rem_reg   <= 17'h00000;
      quo_reg   <= 8'h00;
      cnt_reg   <= 3'h0;
      vmax_reg  <= 16'h0000;
      pick_reg  <= 16'h0000;
      min_reg   <= 16'h0000;
      act_reg   <= 1'b0;
      pct_reg   <= `PCT_FULL;
      eff_reg   <= `PICKUP_RST;
      done_reg  <= 1'b0;
    end else begin
      state_reg <= state_next;
      rem_reg   <= rem_next;
      quo_reg   <= quo_next;
      cnt_reg   <= cnt_next;
      vmax_reg  <= vmax_next;
      pick_reg  <= pick_next;
      min_reg   <= min_next;
      act_reg   <= act_next;
      pct_reg   <= pct_next;
      eff_reg   <= eff_next;
      done_reg  <= done_next;
    end
  end

  assign rif.busy = (state_reg != CALC_IDLE);
  assign rif.done = done_reg;
  assign rif.pct  = pct_reg;
  assign rif.eff  = eff_reg;

endmodule : restraint_calc

// >>> overcurrent_pickup_asserts.sv
// Checker for the overcurrent pickup block, bound to its top-level ports.
// Assumes one clock domain with the asynchronous active-low reset.
`timescale 1ns/10ps
module overcurrent_pickup_asserts (
  // Clock and reset
  input wire logic        clk,
  input wire logic        rstn,
  // Register port
  input wire logic        rd_en,
  input wire logic [31:0] rd_data,
  // Stimulus seen by the block
  input wire logic        sample_valid,
  input wire logic        vts_mcb_trip,
  // Element outputs
  input wire logic        element_pickup,
  input wire logic        restraint_blocked,
  input wire logic [7:0]  active_tmult,
  input wire logic [15:0] measured_quantity,
  input wire logic [15:0] effective_pickup,
  input wire logic        irq
);
  // ==================================================================
  // Properties
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  logic above;
  assign above = measured_quantity > effective_pickup;

  rd_idle_a: assert property (!$past(rd_en) |-> rd_data == 32'h0)
    else $error("read data not zero outside read slot");
  blocked_no_pick_a: assert property (
    restraint_blocked && $past(restraint_blocked) |-> !element_pickup)
    else $error("pickup while restraint blocked");
  block_cause_a: assert property ($rose(restraint_blocked) |-> vts_mcb_trip)
    else $error("blocking without breaker trip");
  pick_cmp_a: assert property (element_pickup |-> $past(above))
    else $error("pickup without quantity above threshold");
  pick_nonzero_a: assert property (element_pickup |-> $past(measured_quantity) != 16'h0)
    else $error("pickup with zero measured quantity");
  meas_on_sample_a: assert property ($changed(measured_quantity) |-> $past(sample_valid))
    else $error("measured quantity moved without sample");
  eff_hold_a: assert property (sample_valid |=> $stable(effective_pickup) [*2])
    else $error("threshold changed too early after sample");
  tmult_keep_a: assert property ($rose(restraint_blocked) |-> $stable(active_tmult))
    else $error("multiplier changed by restraint");

  // Main scenarios reached
  cover property ($rose(element_pickup));
  cover property ($rose(restraint_blocked));
  cover property ($rose(irq));
endmodule : overcurrent_pickup_asserts

bind overcurrent_pickup overcurrent_pickup_asserts u_chk (
  .clk(clk), .rstn(rstn), .rd_en(rd_en), .rd_data(rd_data), .sample_valid(sample_valid),
  .vts_mcb_trip(vts_mcb_trip), .element_pickup(element_pickup),
  .restraint_blocked(restraint_blocked), .active_tmult(active_tmult),
  .measured_quantity(measured_quantity), .effective_pickup(effective_pickup), .irq(irq));

// >>> tb_overcurrent_pickup.sv
// Self-checking bench for the overcurrent pickup block.
// Assumes a 40 MHz clock; read results are checked from a queue of notes.
`timescale 1ns/10ps
module tb_overcurrent_pickup;
  import overcurrent_pkg::*;
  logic        clk, rstn, wr_en, rd_en, sample_valid, vts_mcb_trip, undervoltage_pickup;
  logic [7:0]  addr, rnd, active_tmult;
  logic [31:0] wr_data, rd_data;
  logic [15:0] v_pp_mag, v_pg_mag, i1_re, measured_quantity, effective_pickup, v;
  logic        element_pickup, restraint_blocked, irq, rd_dly;
  logic [3:0]  active_curve;
  logic [1:0]  active_reset_mode;
  logic [63:0] exp_q[$];
  logic [63:0] note;
  logic [15:0] vtab [6] = '{16'h10, 16'h40, 16'h41, 16'hff, 16'h100, 16'h300};
  int          error_cnt, samples_checked, cyc, k;

  overcurrent_pickup uut (
    .clk(clk), .rstn(rstn), .addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en),
    .rd_data(rd_data), .sample_valid(sample_valid), .v_pp_mag(v_pp_mag), .v_pg_mag(v_pg_mag),
    .i1_re(i1_re), .i1_im(16'h0), .i2_re(16'h0), .i2_im(16'h0), .i3_re(16'h0), .i3_im(16'h0),
    .vts_mcb_trip(vts_mcb_trip), .undervoltage_pickup(undervoltage_pickup),
    .element_pickup(element_pickup), .restraint_blocked(restraint_blocked),
    .active_curve(active_curve), .active_reset_mode(active_reset_mode),
    .active_tmult(active_tmult), .measured_quantity(measured_quantity),
    .effective_pickup(effective_pickup), .irq(irq));

  // ==================================================================
  // Helpers
  task check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask : check
  task final_report;
    $display("error_cnt=%0d samples_checked=%0d", error_cnt, samples_checked);
    if (error_cnt == 0 && samples_checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : final_report
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a; wr_data <= d; wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask : wr
  task rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    @(posedge clk);
    addr <= a; rd_en <= 1'b1; exp_q.push_back({m, e});
    @(posedge clk);
    rd_en <= 1'b0;
  endtask : rd
  // Spacing above the longest recompute so every sample lands
  task smp(input logic [15:0] vpp, input logic [15:0] vpg);
    @(posedge clk);
    v_pp_mag <= vpp; v_pg_mag <= vpg; sample_valid <= 1'b1;
    @(posedge clk);
    sample_valid <= 1'b0;
    repeat (16) @(posedge clk);
  endtask : smp
  // Upper voltage 0x100 makes the percent equal the voltage between the knees
  function automatic logic [31:0] pct_of(input logic [15:0] x);
    if (x <= 16'h40) return 32'h40;
    if (x >= 16'h100) return 32'h100;
    return {16'h0, x};
  endfunction : pct_of
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : lfsr

  // ==================================================================
  // Clock, monitor, timeout
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk) rd_dly <= rd_en;
  always @(negedge clk) begin
    if (rd_dly) begin
      note = exp_q.pop_front();
      check(rd_data & note[63:32], note[31:0]);
    end
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      error_cnt++;
      final_report();
    end
  end

  // ==================================================================
  // Main sequence
  initial begin
    {rstn, wr_en, rd_en, sample_valid, vts_mcb_trip, undervoltage_pickup} = 6'h0;
    {addr, wr_data, v_pp_mag, v_pg_mag} = '0;
    i1_re = 16'h3000;
    rnd = 8'h28;
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    wr(8'h40, 32'h5a5a);
    rd(8'h00, '1, 32'h0);
    rd(8'h0c, '1, 32'h1000);
    rd(8'h10, '1, 32'h100);
    rd(8'h14, '1, 32'h64);
    rd(8'h18, '1, 32'h100);
    rd(8'h40, '1, 32'h0);
    wr(8'h00, 32'h1);
    wr(8'h14, 32'h100);
    wr(8'h04, 32'h5507);
    wr(8'h08, 32'haa39);
    wr(8'h30, 32'h7);
    for (k = 0; k < 10; k++) begin
      rnd = lfsr(rnd);
      v = (k < 6) ? vtab[k] : {8'h0, rnd} + 16'h10;
      smp(v, 16'h0);
      rd(8'h20, '1, pct_of(v));
      rd(8'h24, '1, pct_of(v) << 4);
    end
    wr(8'h10, 32'h800);
    smp(16'h10, 16'h0);
    rd(8'h24, '1, 32'h800);
    wr(8'h10, 32'h100);
    rd(8'h28, '1, 32'h3000);
    wr(8'h00, 32'h5);
    smp(16'h100, 16'h0);
    rd(8'h28, '1, 32'h1000);
    check({active_curve, measured_quantity}, {4'h3, 16'h1000});
    wr(8'h00, 32'h1);
    smp(16'h80, 16'h300);
    rd(8'h20, '1, 32'h80);
    wr(8'h00, 32'h0);
    smp(16'h10, 16'h94);
    rd(8'h20, '1, 32'h100);
    wr(8'h00, 32'h2);
    smp(16'h80, 16'h300);
    rd(8'h20, '1, 32'h80);
    wr(8'h04, 32'h5506);
    smp(16'h10, 16'h0);
    rd(8'h24, '1, 32'h1000);
    wr(8'h04, 32'h5507);
    wr(8'h00, 32'h9);
    wr(8'h2c, 32'h7);
    vts_mcb_trip <= 1'b1;
    smp(16'h10, 16'h0);
    rd(8'h1c, 32'h2, 32'h2);
    rd(8'h20, '1, 32'h100);
    rd(8'h2c, 32'h2, 32'h2);
    check({irq, element_pickup, active_tmult}, {2'b10, 8'h55});
    wr(8'h2c, 32'h7);
    repeat (2) @(posedge clk);
    check({irq, restraint_blocked}, 2'b01);
    vts_mcb_trip <= 1'b0;
    wr(8'h00, 32'h11);
    undervoltage_pickup <= 1'b1;
    repeat (3) @(posedge clk);
    check({active_curve, active_reset_mode, active_tmult}, {4'hc, 2'h1, 8'haa});
    rd(8'h1c, 32'h4, 32'h4);
    undervoltage_pickup <= 1'b0;
    repeat (3) @(posedge clk);
    check({active_tmult, effective_pickup}, {8'h55, 16'h1000});
    repeat (3) @(posedge clk);
    final_report();
  end
endmodule : tb_overcurrent_pickup
